// ---- verilog/rtoc_pkg.sv ----
package rtoc_pkg;

  localparam int NUM_RELAYS   = 4;
  localparam int CNT_W        = 32;
  localparam int THR_W        = 21;
  localparam int PER_W        = 10;
  localparam int TMR_W        = 16;
  localparam int ADDR_W       = 8;
  localparam int DATA_W       = 32;

  // threshold and period limits, accepted range of each relay threshold and period
  localparam logic signed [THR_W-1:0] THR_MIN = -21'sh1869f;
  localparam logic signed [THR_W-1:0] THR_MAX = 21'shf423f;
  localparam logic [PER_W-1:0]        PER_MAX = 10'h3e7;

  // clock and time base
  localparam longint CLK_HZ        = 50000000;
  localparam longint TENTH_MS      = 100;
  localparam longint TENTH_CYCLES  = CLK_HZ * TENTH_MS / 1000;
  // a period in tenths of a minute is this many tenth-second ticks per step
  localparam logic [TMR_W-1:0] SEC_PER_MIN = 16'h003c;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_BUSCMD  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_MAIN    = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_CYCLES  = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_RLY_BASE = 8'h20;
  localparam int                RLY_STRIDE_LG = 4;
  localparam logic [3:0]        RLY_OFS_THR  = 4'h0;
  localparam logic [3:0]        RLY_OFS_CFG  = 4'h4;

  // control register fields
  localparam int CTRL_MARK_BIT   = 0;
  localparam int CTRL_AZERO_BIT  = 1;
  localparam int CTRL_DIRREV_BIT = 2;
  localparam int CTRL_CLRM_BIT   = 3;
  localparam int CTRL_CLRC_BIT   = 4;

  // relay config register fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_UNIT_BIT = 4;
  localparam int CFG_SRC_BIT  = 8;
  localparam int CFG_PER_LSB  = 16;

  typedef enum logic [1:0] {
    RTOC_OUTPUT_INACTIVE,
    RTOC_CLOSING,
    RTOC_OPENING,
    RTOC_BUS
  } rtoc_mode_t;

  typedef struct packed {
    logic signed [THR_W-1:0] threshold;
    rtoc_mode_t              mode;
    logic                    unitMinutes;
    logic                    srcCycles;
    logic [PER_W-1:0]        period;
  } rtoc_relay_cfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } rtoc_bus_req_t;

endpackage

// ---- verilog/rtoc_relay_threshold_output_control.sv ----
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/10ps
module rtoc_relay_threshold_output_control #(
  parameter longint TENTH_CYCLES = rtoc_pkg::TENTH_CYCLES
) (
  input  wire logic                            ref_clk,
  input  wire logic                            rst_n,
  input  wire logic                            quadA,
  input  wire logic                            quadB,
  input  wire logic [rtoc_pkg::ADDR_W-1:0]     regAddr,
  input  wire logic [rtoc_pkg::DATA_W-1:0]     regWdata,
  input  wire logic                            regWr,
  input  wire logic                            regRd,
  output logic      [rtoc_pkg::DATA_W-1:0]     regRdata,
  output logic      [rtoc_pkg::NUM_RELAYS-1:0] relayClosed,
  output logic      [rtoc_pkg::NUM_RELAYS-1:0] relayLed
);

  localparam int N = rtoc_pkg::NUM_RELAYS;
  localparam int DATA_W_C = rtoc_pkg::DATA_W;
  localparam int TICK_W = 32;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TENTH_CYCLES - 1);

  logic                      rstSync1;
  logic                      rstSyncN;
  logic [1:0]                aSync;
  logic [1:0]                bSync;
  logic                      aPrev_q;
  logic                      bPrev_q;
  logic [2:0]                syncPrimed_q;
  rtoc_pkg::rtoc_bus_req_t   req;
  logic                      markOp_q;
  logic                      autoZero_q;
  logic                      dirRev_q;
  logic [N-1:0]              busCmd_q;
  rtoc_pkg::rtoc_relay_cfg_t cfg_q [N];
  logic signed [rtoc_pkg::CNT_W-1:0] mainCnt_q;
  logic signed [rtoc_pkg::CNT_W-1:0] mainCnt_d;
  logic signed [rtoc_pkg::CNT_W-1:0] cycCnt_q;
  logic signed [rtoc_pkg::CNT_W-1:0] cycCnt_d;
  logic [TICK_W-1:0]         tick_q;
  logic [N-1:0]              closed_d;
  logic [DATA_W_C-1:0]       rdata_d;

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstSync1 <= 1'b0;
      rstSyncN <= 1'b0;
    end
    else
    begin
      rstSync1 <= 1'b1;
      rstSyncN <= rstSync1;
    end
  end

  // quadrature pins are asynchronous: two flops before use
  always_ff @(posedge ref_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      aSync   <= 2'h0;
      bSync   <= 2'h0;
      aPrev_q <= 1'b0;
      bPrev_q <= 1'b0;
    end
    else
    begin
      aSync   <= {aSync[0], quadA};
      bSync   <= {bSync[0], quadB};
      aPrev_q <= aSync[1];
      bPrev_q <= bSync[1];
    end
  end

  // a pin resting high reads as a step until the synchroniser and the
  // previous-level flops hold real levels, so no count before that
  always_ff @(posedge ref_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      syncPrimed_q <= '0;
    else
      syncPrimed_q <= {syncPrimed_q[1:0], 1'b1};
  end

  wire quadStep = syncPrimed_q[2] &&
                  ((aSync[1] ^ aPrev_q) ^ (bSync[1] ^ bPrev_q));
  wire phaseUp  = aPrev_q ^ bSync[1];
  // a direction change may make the count jump; software clears first
  wire countUp  = phaseUp ^ dirRev_q;

  // register decode
  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
  wire isRlyWin = req.addr >= rtoc_pkg::ADDR_RLY_BASE;
  wire [rtoc_pkg::ADDR_W-1:0] rlyOfs = req.addr - rtoc_pkg::ADDR_RLY_BASE;
  wire [1:0] rlyIdx = rlyOfs[rtoc_pkg::RLY_STRIDE_LG +: 2];
  wire [3:0] rlyReg = rlyOfs[3:0];
  wire rlyHit = isRlyWin &&
                (rlyOfs < (rtoc_pkg::ADDR_W)'(N << rtoc_pkg::RLY_STRIDE_LG));
  wire wrCtrl  = req.wr && (req.addr == rtoc_pkg::ADDR_CTRL);
  wire wrBus   = req.wr && (req.addr == rtoc_pkg::ADDR_BUSCMD);
  wire wrThr   = req.wr && rlyHit && (rlyReg == rtoc_pkg::RLY_OFS_THR);
  wire wrCfg   = req.wr && rlyHit && (rlyReg == rtoc_pkg::RLY_OFS_CFG);
  wire swClrM  = wrCtrl && req.wdata[rtoc_pkg::CTRL_CLRM_BIT];
  wire swClrC  = wrCtrl && req.wdata[rtoc_pkg::CTRL_CLRC_BIT];

  // out-of-range thresholds are pinned to the nearest limit
  wire signed [DATA_W_C-1:0] wrVal = req.wdata;
  wire signed [rtoc_pkg::THR_W-1:0] thrClamped =
    (wrVal < DATA_W_C'(rtoc_pkg::THR_MIN)) ? rtoc_pkg::THR_MIN :
    (wrVal > DATA_W_C'(rtoc_pkg::THR_MAX)) ? rtoc_pkg::THR_MAX :
    wrVal[rtoc_pkg::THR_W-1:0];
  wire [rtoc_pkg::PER_W-1:0] perWr = req.wdata[rtoc_pkg::CFG_PER_LSB +: rtoc_pkg::PER_W];
  wire [rtoc_pkg::PER_W-1:0] perClamped =
    (perWr > rtoc_pkg::PER_MAX) ? rtoc_pkg::PER_MAX : perWr;
  wire rtoc_pkg::rtoc_mode_t modeWr =
    rtoc_pkg::rtoc_mode_t'(req.wdata[rtoc_pkg::CFG_MODE_LSB +: 2]);

  always_ff @(posedge ref_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      markOp_q   <= 1'b0;
      autoZero_q <= 1'b0;
      dirRev_q   <= 1'b0;
      busCmd_q   <= '0;
    end
    else
    begin
      if (wrCtrl)
      begin
        markOp_q   <= req.wdata[rtoc_pkg::CTRL_MARK_BIT];
        autoZero_q <= req.wdata[rtoc_pkg::CTRL_AZERO_BIT];
        dirRev_q   <= req.wdata[rtoc_pkg::CTRL_DIRREV_BIT];
      end
      if (wrBus)
        busCmd_q <= req.wdata[N-1:0];
    end
  end

  // one tick per tenth of a second drives every activation timer
  // the tick runs free, so the first tenth after a trigger may be short
  wire tenthTick = (tick_q == TICK_LAST);
  always_ff @(posedge ref_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      tick_q <= '0;
    else
      tick_q <= tenthTick ? '0 : tick_q + 1'b1;
  end

  wire signed [rtoc_pkg::CNT_W-1:0] thr1 = rtoc_pkg::CNT_W'(cfg_q[0].threshold);
  wire signed [rtoc_pkg::CNT_W-1:0] thr2 = rtoc_pkg::CNT_W'(cfg_q[1].threshold);
  wire signed [rtoc_pkg::CNT_W-1:0] stepVal = countUp ? 32'sh1 : -32'sh1;

  // main counter clears at relay one threshold when marker mode or autozero is set
  wire mainAuto = (mainCnt_q == thr1) &&
                  (markOp_q || autoZero_q);
  // marker mode: cycles counter carries global length
  wire cycAuto  = markOp_q && autoZero_q && (cycCnt_q == thr2);

  always_comb
  begin
    mainCnt_d = mainCnt_q;
    if (swClrM || mainAuto)
      mainCnt_d = '0;
    else if (quadStep)
      mainCnt_d = mainCnt_q + stepVal;
  end

  // standard mode: cycles counter counts autoresets of the main counter
  always_comb
  begin
    cycCnt_d = cycCnt_q;
    if (swClrC || cycAuto)
      cycCnt_d = '0;
    else if (markOp_q && quadStep)
      cycCnt_d = cycCnt_q + stepVal;
    else if (!markOp_q && mainAuto)
      cycCnt_d = cycCnt_q + 32'sh1;
  end

  always_ff @(posedge ref_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      mainCnt_q <= '0;
      cycCnt_q  <= '0;
    end
    else
    begin
      mainCnt_q <= mainCnt_d;
      cycCnt_q  <= cycCnt_d;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++)
    begin : gRelay
      logic             reachPrev_q;
      logic [rtoc_pkg::TMR_W-1:0] timer_q;
      logic signed [rtoc_pkg::CNT_W-1:0] cmpVal;
      wire  useCycles;

      if (gi == 0)
        assign useCycles = 1'b0;
      else if (gi == 1)
        assign useCycles = markOp_q;
      else
        assign useCycles = cfg_q[gi].srcCycles;

      assign cmpVal = useCycles ? cycCnt_q : mainCnt_q;
      wire reach = cmpVal >= rtoc_pkg::CNT_W'(cfg_q[gi].threshold);
      // retrigger only on a fresh crossing, not while the value stays above
      wire reachEvt = reach && !reachPrev_q;
      wire selThis = (rlyIdx == 2'(gi));
      wire perZero = (cfg_q[gi].period == '0);
      wire [rtoc_pkg::TMR_W-1:0] perTenths = rtoc_pkg::TMR_W'(cfg_q[gi].period);
      // period counts tenths of its unit: a tenth of a minute is sixty ticks
      wire [rtoc_pkg::TMR_W-1:0] loadVal = cfg_q[gi].unitMinutes ?
        rtoc_pkg::TMR_W'(perTenths * rtoc_pkg::SEC_PER_MIN) : perTenths;
      // timer ignores later counter clears or value changes
      wire active = perZero ? reach : (timer_q != '0);

      always_comb
      begin
        case (cfg_q[gi].mode)
          rtoc_pkg::RTOC_OUTPUT_INACTIVE: closed_d[gi] = 1'b0;
          rtoc_pkg::RTOC_CLOSING:         closed_d[gi] = active;
          rtoc_pkg::RTOC_OPENING:         closed_d[gi] = !active;
          rtoc_pkg::RTOC_BUS:             closed_d[gi] = busCmd_q[gi];
          default:                        closed_d[gi] = 1'b0;
        endcase
      end

      always_ff @(posedge ref_clk or negedge rstSyncN)
      begin
        if (!rstSyncN)
        begin
          cfg_q[gi]   <= '{threshold: '0, mode: rtoc_pkg::RTOC_OUTPUT_INACTIVE,
                           unitMinutes: 1'b0, srcCycles: 1'b0, period: '0};
          reachPrev_q <= 1'b0;
          timer_q     <= '0;
        end
        else
        begin
          if (wrThr && selThis)
            cfg_q[gi].threshold <= thrClamped;
          if (wrCfg && selThis)
          begin
            cfg_q[gi].mode        <= modeWr;
            cfg_q[gi].unitMinutes <= req.wdata[rtoc_pkg::CFG_UNIT_BIT];
            cfg_q[gi].srcCycles   <= req.wdata[rtoc_pkg::CFG_SRC_BIT];
            cfg_q[gi].period      <= perClamped;
          end
          reachPrev_q <= reach;
          if (reachEvt && !perZero)
            timer_q <= loadVal;
          else if (tenthTick && (timer_q != '0))
            timer_q <= timer_q - 1'b1;
        end
      end
    end
  endgenerate

  // read mux, data valid the cycle after the strobe
  wire [1:0] selIdx = rlyIdx;
  wire [DATA_W_C-1:0] thrRd = DATA_W_C'(cfg_q[selIdx].threshold);
  wire [DATA_W_C-1:0] cfgRd =
    (DATA_W_C'(cfg_q[selIdx].mode) << rtoc_pkg::CFG_MODE_LSB) |
    (DATA_W_C'(cfg_q[selIdx].unitMinutes) << rtoc_pkg::CFG_UNIT_BIT) |
    (DATA_W_C'(cfg_q[selIdx].srcCycles) << rtoc_pkg::CFG_SRC_BIT) |
    (DATA_W_C'(cfg_q[selIdx].period) << rtoc_pkg::CFG_PER_LSB);
  wire [DATA_W_C-1:0] ctrlRd =
    (DATA_W_C'(markOp_q) << rtoc_pkg::CTRL_MARK_BIT) |
    (DATA_W_C'(autoZero_q) << rtoc_pkg::CTRL_AZERO_BIT) |
    (DATA_W_C'(dirRev_q) << rtoc_pkg::CTRL_DIRREV_BIT);

  always_comb
  begin
    rdata_d = '0;
    if (req.rd)
    begin
      if (req.addr == rtoc_pkg::ADDR_CTRL)
        rdata_d = ctrlRd;
      else if (req.addr == rtoc_pkg::ADDR_BUSCMD)
        rdata_d = DATA_W_C'(busCmd_q);
      else if (req.addr == rtoc_pkg::ADDR_STATUS)
        rdata_d = DATA_W_C'(relayClosed);
      else if (req.addr == rtoc_pkg::ADDR_MAIN)
        rdata_d = mainCnt_q;
      else if (req.addr == rtoc_pkg::ADDR_CYCLES)
        rdata_d = cycCnt_q;
      else if (rlyHit && (rlyReg == rtoc_pkg::RLY_OFS_THR))
        rdata_d = thrRd;
      else if (rlyHit && (rlyReg == rtoc_pkg::RLY_OFS_CFG))
        rdata_d = cfgRd;
    end
  end

  always_ff @(posedge ref_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      regRdata    <= '0;
      relayClosed <= '0;
      relayLed    <= '0;
    end
    else
    begin
      regRdata    <= rdata_d;
      relayClosed <= closed_d;
      relayLed    <= closed_d;
    end
  end

endmodule

// ---- bench/rtoc_encoder_model.sv ----
`timescale 1ns/10ps
module rtoc_encoder_model (
  input  wire logic ref_clk,
  input  wire logic stepUp,
  input  wire logic stepDn,
  output logic      quadA,
  output logic      quadB
);
  logic [1:0] phase_q = 2'h0;
  always_ff @(posedge ref_clk)
  begin
    if (stepUp)
      phase_q <= phase_q + 2'h1;
    else if (stepDn)
      phase_q <= phase_q - 2'h1;
  end
  // gray order: only one line moves per step, as a real encoder does
  assign quadA = phase_q[1];
  assign quadB = phase_q[1] ^ phase_q[0];
endmodule

// ---- bench/rtoc_relay_props.sv ----
`timescale 1ns/10ps
module rtoc_relay_props (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdata,
  input wire logic [3:0]  relayClosed,
  input wire logic [3:0]  relayLed
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [3:0][1:0] mode_q;
  logic [3:0]      bus_q;
  logic [3:0]      isBus;
  logic [3:0]      isOff;
  // shadow of mode and bus command writes, seen only from the bus
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q <= '0;
      bus_q  <= 4'h0;
    end
    else if (regWr)
    begin
      if (regAddr == 8'h04)
        bus_q <= regWdata[3:0];
      for (int i = 0; i < 4; i++)
        if (regAddr == 8'(i * 16) + 8'h24)
          mode_q[i] <= regWdata[1:0];
    end
  end
  for (genvar i = 0; i < 4; i++)
  begin : g_rly
    assign isBus[i] = mode_q[i] == 2'h3;
    assign isOff[i] = mode_q[i] == 2'h0;
    a_inactive_open: assert property (isOff[i] && $past(isOff[i]) |-> !relayClosed[i])
      else $error("relay closed while inactive");
    a_bus_follow: assert property (isBus[i] && $past(isBus[i], 2) && $past(bus_q, 2) == bus_q
      |-> relayClosed[i] == bus_q[i])
      else $error("relay differs from bus command");
    a_bus_write: assert property (isBus[i] && regWr && regAddr == 8'h04
      |-> ##2 relayClosed[i] == $past(regWdata[i], 2))
      else $error("bus command not applied");
  end
  a_led_equal: assert property (relayLed == relayClosed)
    else $error("led differs from relay");
  a_status_read: assert property ($past(regRd) && $past(regAddr) == 8'h08 && $stable(relayClosed)
    |-> regRdata == {28'h0, relayClosed})
    else $error("status differs from relays");
  a_reset_open: assert property ($rose(rst_n) |-> relayClosed == 4'h0 [*3])
    else $error("relay closed after reset");
  a_inactive_write: assert property (regWr && regAddr == 8'h24 && regWdata[1:0] == 2'h0
    |-> ##2 !relayClosed[0])
    else $error("relay one still closed");
  a_bus_steady: assert property (isBus[0] && $past(isBus[0], 3) && $past(bus_q, 3) == bus_q
    |-> $stable(relayClosed[0]))
    else $error("bus relay moved by itself");
  c_bus: cover property (isBus[0] && relayClosed[0]);
  c_close: cover property ($rose(relayClosed[0]));
  c_marker: cover property (regWr && regAddr == 8'h00 && regWdata[0]);
endmodule

bind rtoc_relay_threshold_output_control rtoc_relay_props u_props (
  .ref_clk    (ref_clk),
  .rst_n      (rst_n),
  .regAddr    (regAddr),
  .regWdata   (regWdata),
  .regWr      (regWr),
  .regRd      (regRd),
  .regRdata   (regRdata),
  .relayClosed(relayClosed),
  .relayLed   (relayLed)
);

// ---- bench/relay_threshold_output_control_test.sv ----
`timescale 1ns/10ps
module relay_threshold_output_control_test;
  localparam longint TC = 10;
  logic        ref_clk  = 1'b0;
  logic        rst_n    = 1'b0;
  logic        stepUp   = 1'b0;
  logic        stepDn   = 1'b0;
  logic        quadA;
  logic        quadB;
  logic [7:0]  regAddr  = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic        regWr    = 1'b0;
  logic        regRd    = 1'b0;
  logic [31:0] regRdata;
  logic [3:0]  relayClosed;
  logic [3:0]  relayLed;
  int          bad_count = 0;
  int          compares  = 0;
  always #10 ref_clk = ~ref_clk;
  rtoc_encoder_model enc (.ref_clk(ref_clk), .stepUp(stepUp), .stepDn(stepDn),
    .quadA(quadA), .quadB(quadB));
  rtoc_relay_threshold_output_control #(.TENTH_CYCLES(TC)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .quadA(quadA), .quadB(quadB),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .relayClosed(relayClosed), .relayLed(relayLed));
  task automatic finish_test;
    $display("compares %0d, wrong %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge ref_clk);
    regWr    <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd   <= 1'b0;
    #1;
    cmp(regRdata, e);
  endtask
  // one update of relays follows each write or count, so allow two edges
  task automatic chkRly(input logic [3:0] e);
    repeat (2) @(posedge ref_clk);
    #1;
    cmp({28'h0, relayClosed}, {28'h0, e});
    cmp({28'h0, relayLed}, {28'h0, e});
  endtask
  task automatic step(input int n, input logic up);
    repeat (n)
    begin
      @(posedge ref_clk);
      stepUp <= up;
      stepDn <= !up;
      @(posedge ref_clk);
      stepUp <= 1'b0;
      stepDn <= 1'b0;
      repeat (6) @(posedge ref_clk);
    end
  endtask
  task automatic done(input string s);
    $display("end of test %s", s);
  endtask
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    finish_test;
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chkRly(4'h0);
    chk(8'h24, 32'h0);
    chk(8'h14, 32'h0);
    done("reset");
    wr(8'h20, 32'h00100000);
    chk(8'h20, 32'h000f423f);
    wr(8'h20, 32'hfffcf2c0);
    chk(8'h20, 32'hfffe7961);
    wr(8'h24, 32'h03ff0000);
    chk(8'h24, 32'h03e70000);
    done("clamp");
    wr(8'h24, 32'h1);
    wr(8'h20, 32'h3);
    wr(8'h30, 32'h2);
    wr(8'h34, 32'h2);
    chkRly(4'h2);
    step(2, 1'b1);
    chkRly(4'h0);
    step(1, 1'b1);
    chkRly(4'h1);
    chk(8'h0c, 32'h3);
    step(1, 1'b0);
    chkRly(4'h0);
    done("compare");
    wr(8'h00, 32'h1c);
    step(2, 1'b1);
    chk(8'h0c, 32'hfffffffe);
    chkRly(4'h2);
    wr(8'h00, 32'h18);
    done("direction");
    wr(8'h20, 32'hfffffffb);
    wr(8'h24, 32'h0);
    wr(8'h34, 32'h0);
    chkRly(4'h0);
    wr(8'h24, 32'h1);
    chkRly(4'h1);
    done("inactive");
    wr(8'h24, 32'h3);
    wr(8'h44, 32'h3);
    wr(8'h04, 32'h5);
    chkRly(4'h5);
    chk(8'h08, 32'h5);
    step(1, 1'b1);
    chkRly(4'h5);
    wr(8'h04, 32'h4);
    chkRly(4'h4);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chkRly(4'h0);
    chk(8'h0c, 32'h0);
    wr(8'h24, 32'h3);
    chkRly(4'h0);
    done("bus");
    wr(8'h20, 32'h1);
    wr(8'h24, 32'h00020001);
    step(1, 1'b1);
    wr(8'h00, 32'h08);
    chkRly(4'h1);
    repeat (30) @(posedge ref_clk);
    chkRly(4'h0);
    wr(8'h24, 32'h00020011);
    step(1, 1'b1);
    wr(8'h00, 32'h08);
    repeat (30) @(posedge ref_clk);
    chkRly(4'h1);
    repeat (1200) @(posedge ref_clk);
    chkRly(4'h0);
    wr(8'h24, 32'h0);
    done("timed");
    wr(8'h00, 32'h1a);
    wr(8'h20, 32'h2);
    wr(8'h50, 32'h1);
    wr(8'h54, 32'h101);
    step(2, 1'b1);
    chk(8'h0c, 32'h0);
    chk(8'h10, 32'h1);
    chkRly(4'h8);
    done("autozero");
    wr(8'h30, 32'h3);
    wr(8'h34, 32'h00140001);
    wr(8'h00, 32'h1b);
    step(3, 1'b1);
    chk(8'h0c, 32'h1);
    chk(8'h10, 32'h0);
    chkRly(4'h2);
    wr(8'h00, 32'h19);
    step(2, 1'b1);
    chk(8'h0c, 32'h0);
    chk(8'h10, 32'h2);
    done("marker");
    finish_test;
  end
endmodule
